// ===== sas_defs.svh
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// Register indices, byte address is four times the index
`define SAS_IDX_CSR 8'h2e
`define SAS_IDX_RESH 8'h2f
`define SAS_IDX_RESL 8'h30
`define SAS_IDX_IRQ_STAT 8'h31
`define SAS_IDX_IRQ_MASK 8'h32
`define SAS_IDX_PWR 8'h33
`define SAS_ADDR_W 10

// Control/status fields
`define SAS_CSR_DONE_BIT 7
`define SAS_CSR_DIV_HI 6
`define SAS_CSR_DIV_LO 5
`define SAS_CSR_ON_BIT 4
`define SAS_CSR_CS_HI 3
`define SAS_CSR_CS_LO 0
`define SAS_CSR_RESET 8'h00
`define SAS_RES_RESET 8'h00

// Power/aux register fields
`define SAS_PWR_IRQEN_BIT 0
`define SAS_PWR_HALT_BIT 1
`define SAS_PWR_WAIT_BIT 2

// Saturated results
`define SAS_SAT_HI_H 8'hff
`define SAS_SAT_HI_L 8'h03
`define SAS_SAT_LO 8'h00

// Clocks
`define SAS_CLK_HZ 20000000
`define SAS_F4_HZ 4000000
`define SAS_F2_HZ 2000000
`define SAS_F1_HZ 1000000
`define SAS_DIV4 (`SAS_CLK_HZ / `SAS_F4_HZ)
`define SAS_DIV2 (`SAS_CLK_HZ / `SAS_F2_HZ)
`define SAS_DIV1 (`SAS_CLK_HZ / `SAS_F1_HZ)

// Converter timing in converter clock ticks
`define SAS_SAMPLE_TICKS 3
`define SAS_STAB_TICKS 8

`endif

// ===== sas_pkg.sv
`include "sas_defs.svh"

package sas_pkg;
  typedef enum logic [3:0] {
    SAS_IDLE = 4'b0001,
    SAS_STAB = 4'b0010,
    SAS_SAMP = 4'b0100,
    SAS_CONV = 4'b1000
  } sas_state_e;

  typedef logic [7:0] sas_byte_t;
endpackage : sas_pkg

// ===== sas_adc_seq.sv
// What this block does
// - Input above high reference gives ffh/03h
// - Input below low reference gives zero
// - Four-bit channel code selects input 0-15
// - converter_on starts continuous repeated conversions
// - Done flag cleared when conversion starts from idle
// - Channel write mid-conversion restarts on new channel
// - Completion sets flag, interrupt if enabled
// - Result held until next conversion finishes
// - High byte read clears done flag
// - Low byte read freezes both result bytes
// - High read or converter off unfreezes
// - Divider code 00/01/10 gives 4/2/1 MHz
// - Clearing converter_on stops conversion in progress
// - High byte bits 9:2, low byte bits 1:0
// - Runs in wait, off in halt, stabilises after
`include "sas_defs.svh"

module sas_adc_seq #(
  parameter int unsigned SAMPLE_TICKS = `SAS_SAMPLE_TICKS,
  parameter int unsigned STAB_TICKS = `SAS_STAB_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SAS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] channel_sel,
  output logic sample_hold,
  output logic converter_power,
  output logic [9:0] sar_trial,
  input wire logic cmp_above,
  input wire logic over_high_ref,
  input wire logic under_low_ref,
  input wire logic long_sample_select,
  input wire logic core_halt,
  output logic irq,
  output logic wake_req
);
  import sas_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    sas_state_e st;
    logic [2:0] ack;
    logic wreq;
    logic [31:0] rdata;
    logic done;
    logic [1:0] div_sel;
    logic on;
    logic [3:0] cs;
    logic [7:0] res_h;
    logic [1:0] res_l;
    logic frozen;
    logic irq_en;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [4:0] pre;
    logic tick;
    logic [3:0] tcnt;
    logic [3:0] bitn;
    logic [9:0] sar;
    logic halt_seen;
    logic irq_o;
    logic wake_o;
  } sas_state_s;

  sas_state_s s_r;
  sas_state_s s_nxt;

  logic [4:0] div_lim;
  logic [3:0] samp_len;
  logic bus_req;
  logic rd_ev;
  logic wr_ev;
  logic [7:0] idx;
  logic [7:0] wb;
  logic conv_done;
  logic [9:0] final_res;
  logic lock_now;

  ////////////////////////////////////////////////////////////////////////
  // Combinational

  always_comb begin
    s_nxt = s_r;
    bus_req = avs_read | avs_write;
    idx = avs_address[`SAS_ADDR_W-1:2];
    wb = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    rd_ev = avs_read & (s_r.ack == 3'h1);
    wr_ev = avs_write & (s_r.ack == 3'h1) & avs_byteenable[0];
    lock_now = rd_ev & (idx == `SAS_IDX_RESL);
    conv_done = 1'b0;
    final_res = 10'h000;

    // Bus handshake: one wait cycle then accept
    if (bus_req && s_r.ack == 3'h0) begin
      s_nxt.ack = 3'h1;
    end else if (s_r.ack == 3'h1) begin
      s_nxt.ack = 3'h2;
    end else begin
      s_nxt.ack = 3'h0;
    end
    s_nxt.wreq = (s_nxt.ack != 3'h1);

    // Prescaler
    case (s_r.div_sel)
      2'b00: div_lim = 5'(`SAS_DIV4 - 1);
      2'b01: div_lim = 5'(`SAS_DIV2 - 1);
      2'b10: div_lim = 5'(`SAS_DIV1 - 1);
      default: div_lim = 5'(`SAS_DIV1 - 1);
    endcase
    s_nxt.tick = 1'b0;
    if (!s_r.on) begin
      s_nxt.pre = 5'h00;
    end else if (s_r.pre >= div_lim) begin
      s_nxt.pre = 5'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 5'h01;
    end

    samp_len = long_sample_select ? 4'(2 * SAMPLE_TICKS) : 4'(SAMPLE_TICKS);

    // Conversion sequencer
    case (s_r.st)
      SAS_IDLE: begin
        if (s_r.on && !core_halt) begin
          s_nxt.st = s_r.halt_seen ? SAS_STAB : SAS_SAMP;
          s_nxt.tcnt = 4'h0;
          s_nxt.halt_seen = 1'b0;
        end
      end
      SAS_STAB: begin
        if (s_r.tick) begin
          s_nxt.tcnt = s_r.tcnt + 4'h1;
          if (s_r.tcnt == 4'(STAB_TICKS - 1)) begin
            s_nxt.st = SAS_SAMP;
            s_nxt.tcnt = 4'h0;
          end
        end
      end
      SAS_SAMP: begin
        if (s_r.tick) begin
          s_nxt.tcnt = s_r.tcnt + 4'h1;
          if (s_r.tcnt == samp_len - 4'h1) begin
            s_nxt.st = SAS_CONV;
            s_nxt.bitn = 4'd9;
            s_nxt.sar = 10'h200;
          end
        end
      end
      SAS_CONV: begin
        if (s_r.tick) begin
          s_nxt.sar[s_r.bitn] = cmp_above;
          if (s_r.bitn == 4'd0) begin
            conv_done = 1'b1;
            s_nxt.st = SAS_SAMP;
            s_nxt.tcnt = 4'h0;
          end else begin
            s_nxt.bitn = s_r.bitn - 4'd1;
            s_nxt.sar[s_r.bitn - 4'd1] = 1'b1;
          end
        end
      end
      default: s_nxt.st = SAS_IDLE;
    endcase

    final_res = s_r.sar;
    final_res[0] = cmp_above;
    if (over_high_ref) begin
      final_res = 10'h3ff;
    end else if (under_low_ref) begin
      final_res = 10'h000;
    end

    if (conv_done) begin
      if (!s_r.frozen && !lock_now) begin
        s_nxt.res_h = final_res[9:2];
        s_nxt.res_l = final_res[1:0];
      end
    end

    if (core_halt && s_r.on) begin
      s_nxt.halt_seen = 1'b1;
    end
    if (!s_r.on || core_halt) begin
      s_nxt.st = SAS_IDLE;
    end

    // Read side effects at the accepting edge
    if (rd_ev) begin
      case (idx)
        `SAS_IDX_RESH: begin
          s_nxt.done = 1'b0;
          s_nxt.frozen = 1'b0;
        end
        `SAS_IDX_RESL: s_nxt.frozen = 1'b1;
        default: s_nxt.frozen = s_nxt.frozen;
      endcase
    end

    // Register writes
    if (wr_ev) begin
      case (idx)
        `SAS_IDX_CSR: begin
          s_nxt.div_sel = wb[`SAS_CSR_DIV_HI:`SAS_CSR_DIV_LO];
          s_nxt.on = wb[`SAS_CSR_ON_BIT];
          s_nxt.cs = wb[`SAS_CSR_CS_HI:`SAS_CSR_CS_LO];
          if (wb[`SAS_CSR_CS_HI:`SAS_CSR_CS_LO] != s_r.cs && s_r.st != SAS_IDLE) begin
            s_nxt.st = SAS_SAMP;
            s_nxt.tcnt = 4'h0;
          end
          if (!wb[`SAS_CSR_ON_BIT]) begin
            s_nxt.frozen = 1'b0;
            s_nxt.st = SAS_IDLE;
          end
        end
        `SAS_IDX_IRQ_STAT: s_nxt.stat = s_r.stat & ~wb[1:0];
        `SAS_IDX_IRQ_MASK: s_nxt.mask = wb[1:0];
        `SAS_IDX_PWR: s_nxt.irq_en = wb[`SAS_PWR_IRQEN_BIT];
        default: s_nxt.stat = s_nxt.stat;
      endcase
    end

    // Done flag and events, set wins over clear
    if (s_nxt.st != SAS_IDLE && s_r.st == SAS_IDLE) begin
      s_nxt.done = 1'b0;
    end
    if (conv_done) begin
      s_nxt.done = 1'b1;
      s_nxt.stat[0] = 1'b1;
    end
    if (s_r.on && core_halt && !s_r.halt_seen) begin
      s_nxt.stat[1] = 1'b1;
    end

    s_nxt.irq_o = (|(s_nxt.stat & s_nxt.mask)) | (s_nxt.done & s_nxt.irq_en);
    s_nxt.wake_o = s_nxt.done & s_nxt.irq_en & !core_halt;

    // Read data loads as a read is first seen, stands while waitrequest low
    if (avs_read && s_r.ack == 3'h0) begin
      s_nxt.rdata = 32'h0000_0000;
      case (idx)
        `SAS_IDX_CSR: s_nxt.rdata[7:0] = {s_nxt.done, s_nxt.div_sel, s_nxt.on, s_nxt.cs};
        `SAS_IDX_RESH: s_nxt.rdata[7:0] = s_nxt.res_h;
        `SAS_IDX_RESL: s_nxt.rdata[7:0] = {6'h00, s_nxt.res_l};
        `SAS_IDX_IRQ_STAT: s_nxt.rdata[1:0] = s_nxt.stat;
        `SAS_IDX_IRQ_MASK: s_nxt.rdata[1:0] = s_nxt.mask;
        `SAS_IDX_PWR: s_nxt.rdata[2:0] = {1'b0, core_halt, s_nxt.irq_en};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= SAS_IDLE;
      s_r.wreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.wreq;
  assign channel_sel = s_r.cs;
  assign sample_hold = s_r.st[2];
  assign converter_power = s_r.on;
  assign sar_trial = s_r.sar;
  assign irq = s_r.irq_o;
  assign wake_req = s_r.wake_o;

endmodule : sas_adc_seq

// ===== sas_adc_seq_chk.sv
module sas_adc_seq_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] channel_sel,
  input wire logic sample_hold,
  input wire logic converter_power,
  input wire logic core_halt,
  input wire logic irq,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_bus_answer: assert property ((avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
    else $error("bus request not answered");
  chk_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_off_idle: assert property (!converter_power [*2] |-> !sample_hold)
    else $error("sampling while off");
  chk_on_starts: assert property ($rose(converter_power) |-> ##[1:300] sample_hold)
    else $error("no sampling after on");
  chk_chan_restart: assert property ($changed(channel_sel) && converter_power && !core_halt |-> ##[0:300] sample_hold)
    else $error("no restart on channel change");
  chk_halt_nowake: assert property (core_halt [*2] |-> !wake_req)
    else $error("wake while halted");
  chk_halt_stops: assert property (core_halt [*3] |-> !sample_hold)
    else $error("sampling in halt");
  chk_wake_irq: assert property (wake_req |-> irq)
    else $error("wake without irq");
  cover property (sample_hold ##1 !sample_hold);
  cover property ($rose(wake_req));
  cover property (core_halt ##1 !core_halt);
endmodule : sas_adc_seq_chk

bind sas_adc_seq sas_adc_seq_chk u_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .channel_sel(channel_sel),
  .sample_hold(sample_hold), .converter_power(converter_power), .core_halt(core_halt),
  .irq(irq), .wake_req(wake_req));

// ===== sas_ain_model.sv
module sas_ain_model (
  input wire logic [3:0] channel_sel,
  input wire logic [9:0] sar_trial,
  output logic cmp_above,
  output logic over_high_ref,
  output logic under_low_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  // Level per input, in result codes
  int lvl [16];
  always_comb begin
    cmp_above = lvl[channel_sel] >= int'(sar_trial);
    over_high_ref = lvl[channel_sel] > 1023;
    under_low_ref = lvl[channel_sel] < 0;
  end
endmodule : sas_ain_model

// ===== tb_top.sv
`include "sas_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, long_sample_select = 0, core_halt = 0;
  logic [9:0] avs_address = '0, sar_trial, c;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, lo, hi;
  logic [3:0] avs_byteenable = 4'hf, channel_sel;
  logic avs_waitrequest, sample_hold, converter_power, cmp_above, over_high_ref;
  logic under_low_ref, irq, wake_req;
  int error_cnt = 0, n_compared = 0, seed = 10, lv, n;
  always #25 clk = ~clk;
  sas_adc_seq u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .channel_sel, .sample_hold,
    .converter_power, .sar_trial, .cmp_above, .over_high_ref, .under_low_ref,
    .long_sample_select, .core_halt, .irq, .wake_req);
  sas_ain_model u_ain (.channel_sel, .sar_trial, .cmp_above, .over_high_ref, .under_low_ref);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask : acc
  task automatic conv();
    do acc(`SAS_IDX_CSR, 0, 0); while (rd[7] !== 1'b1);
    acc(`SAS_IDX_RESL, 0, 0);
    lo = rd;
    acc(`SAS_IDX_RESH, 0, 0);
    hi = rd;
  endtask : conv
  function automatic logic [9:0] code(input int v);
    return v > 1023 ? 10'h3ff : v < 0 ? 10'h000 : v[9:0];
  endfunction : code
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    acc(`SAS_IDX_RESH, 1, 8'hff);
    for (int k = 0; k < 4; k++) begin
      acc(k == 3 ? 8'h00 : 8'h2e + k[7:0], 0, 0);
      chk(rd, 0);
    end
    $display("reset and map test done");
    for (int i = 0; i < 16; i++) begin
      lv = i == 14 ? 2000 : i == 15 ? -5 : $random(seed) & 32'h3ff;
      u_ain.lvl[i] <= lv;
      long_sample_select <= i[2];
      acc(`SAS_IDX_CSR, 1, {1'b0, i[1:0], 1'b1, i[3:0]});
      acc(`SAS_IDX_RESH, 0, 0);
      chk(channel_sel, i[3:0]);
      conv();
      c = code(lv);
      chk(lo, {30'h0, c[1:0]});
      chk(hi, {24'h0, c[9:2]});
      while (sample_hold !== 1'b0) @(posedge clk);
      while (sample_hold !== 1'b1) @(posedge clk);
      for (n = 0; sample_hold === 1'b1; n++) @(posedge clk);
      chk(n, (i[1] ? 20 : i[0] ? 10 : 5) * `SAS_SAMPLE_TICKS * (i[2] ? 2 : 1));
    end
    $display("conversion test done");
    acc(`SAS_IDX_RESL, 0, 0);
    u_ain.lvl[15] <= 700;
    repeat (600) @(posedge clk);
    acc(`SAS_IDX_RESH, 0, 0);
    chk(rd, 0);
    conv();
    chk(hi, 32'haf);
    acc(`SAS_IDX_RESL, 0, 0);
    u_ain.lvl[15] <= 301;
    repeat (600) @(posedge clk);
    acc(`SAS_IDX_CSR, 1, 8'h6f);
    acc(`SAS_IDX_CSR, 1, 8'h7f);
    acc(`SAS_IDX_CSR, 0, 0);
    chk(rd[7], 0);
    repeat (600) @(posedge clk);
    acc(`SAS_IDX_RESL, 0, 0);
    chk(rd, 1);
    acc(`SAS_IDX_RESH, 0, 0);
    chk(rd, 32'h4b);
    $display("freeze test done");
    acc(`SAS_IDX_PWR, 1, 8'h01);
    for (n = 0; n < 600 && wake_req !== 1'b1; n++) @(posedge clk);
    chk(wake_req, 1);
    chk(irq, 1);
    acc(`SAS_IDX_IRQ_STAT, 0, 0);
    chk(rd & 1, 1);
    acc(`SAS_IDX_CSR, 1, 8'h6f);
    acc(`SAS_IDX_RESH, 0, 0);
    acc(`SAS_IDX_CSR, 0, 0);
    chk(rd, 32'h6f);
    acc(`SAS_IDX_IRQ_STAT, 1, 8'h03);
    acc(`SAS_IDX_IRQ_STAT, 0, 0);
    chk(rd, 0);
    chk(irq, 0);
    acc(`SAS_IDX_IRQ_MASK, 1, 8'h03);
    acc(`SAS_IDX_IRQ_MASK, 0, 0);
    chk(rd, 3);
    acc(`SAS_IDX_CSR, 1, 8'h7f);
    core_halt <= 1;
    repeat (20) @(posedge clk);
    chk(wake_req, 0);
    acc(`SAS_IDX_IRQ_STAT, 0, 0);
    chk(rd & 2, 2);
    core_halt <= 0;
    repeat (400) @(posedge clk);
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule : tb_top
